// [faf_regs.svh]
`ifndef FAF_REGS_SVH
`define FAF_REGS_SVH

`define FAF_ADDR_W 16
`define FAF_DATA_W 32
`define FAF_THRESH_W 8
`define FAF_BASE_LO_BIT 5
`define FAF_BASE_HI_BIT 11
`define FAF_BASE_THR_HI 3
`define FAF_FILL_LEVEL_DIFFERENCE_CMP_LO 8
`define FAF_BLOCK_BITS 4096
`define FAF_MAX_BLOCKS 16
`define FAF_RST_PTR 16'h0000
`define FAF_RST_EMPTY 1'b1
`define FAF_RST_ALMOST_EMPTY_FLAG 1'b1

`endif

// [faf_pkg.sv]
package faf_pkg;

   // Number of cascaded blocks, as a power of two
   typedef enum logic [2:0]
   {
      FAF_CASC_1 = 3'h0,
      FAF_CASC_2 = 3'h1,
      FAF_CASC_4 = 3'h2,
      FAF_CASC_8 = 3'h3,
      FAF_CASC_16 = 3'h4
   } faf_cascade_t;

   // Word width per block, as a power of two
   typedef enum logic [2:0]
   {
      FAF_W1 = 3'h0,
      FAF_W2 = 3'h1,
      FAF_W4 = 3'h2,
      FAF_W8 = 3'h3,
      FAF_W16 = 3'h4,
      FAF_W32 = 3'h5
   } faf_width_t;

endpackage : faf_pkg

// [faf_fifo_address_flag_logic.sv]
`include "faf_regs.svh"

module faf_fifo_address_flag_logic
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [2:0] cascadeMode,
   input wire logic [2:0] widthMode,
   input wire logic [7:0] fullThresholdValue,
   input wire logic [7:0] emptyThresholdValue,
   input wire logic writeRequest,
   input wire logic [31:0] writeData,
   output logic writeReady,
   input wire logic readRequest,
   output logic readReady,
   output logic [31:0] readData,
   output logic readDataValid,
   output logic [15:0] writeAddress,
   output logic [15:0] readAddress,
   output logic [15:0] fillLevelDifference,
   output logic fullFlag,
   output logic emptyFlag,
   output logic almostFullFlag,
   output logic almostEmptyFlag
);

   ////////////////////////////////////////////////////////////////////////////
   // Configuration decode

   localparam int ADDR_W = `FAF_ADDR_W;
   localparam int DATA_W = `FAF_DATA_W;
   localparam int THR_W = `FAF_THRESH_W;
   localparam int MEM_BITS = `FAF_BLOCK_BITS * `FAF_MAX_BLOCKS;

   logic [2:0] extraHi;
   logic [2:0] lowBit;
   logic [4:0] topBit;
   logic [3:0] thrTopBit;
   logic [6:0] wordWidth;
   logic [ADDR_W-1:0] addrMask;
   logic [THR_W-1:0] thrMask;
   logic [ADDR_W:0] step;
   logic [2:0] cascadeSel_reg;
   logic [2:0] cascadeSel_next;
   logic [2:0] widthSel_reg;
   logic [2:0] widthSel_next;

   // Configuration is taken only while reset is high, so a change in mid-run cannot
   // re-map live pointers or stored words
   always_comb
   begin
      cascadeSel_next = cascadeSel_reg;
      widthSel_next = widthSel_reg;
      if (rst)
      begin
         cascadeSel_next = cascadeMode;
         widthSel_next = widthMode;
      end
   end

   // Configuration registers
   always_ff @(posedge core_clk)
   begin
      cascadeSel_reg <= cascadeSel_next;
      widthSel_reg <= widthSel_next;
   end

   // Cascade count selects the extra block-select bits
   always_comb
   begin
      case (cascadeSel_reg)
         faf_pkg::FAF_CASC_1: extraHi = 3'h0;
         faf_pkg::FAF_CASC_2: extraHi = 3'h1;
         faf_pkg::FAF_CASC_4: extraHi = 3'h2;
         faf_pkg::FAF_CASC_8: extraHi = 3'h3;
         faf_pkg::FAF_CASC_16: extraHi = 3'h4;
         default: extraHi = 3'h0;  // Unused codes act as one block
      endcase
   end

   // Word width selects the lowest active address bit
   always_comb
   begin
      case (widthSel_reg)
         faf_pkg::FAF_W1: lowBit = 3'h0;
         faf_pkg::FAF_W2: lowBit = 3'h1;
         faf_pkg::FAF_W4: lowBit = 3'h2;
         faf_pkg::FAF_W8: lowBit = 3'h3;
         faf_pkg::FAF_W16: lowBit = 3'h4;
         faf_pkg::FAF_W32: lowBit = 3'h5;
         default: lowBit = 3'h5;  // Unused codes act as widest word
      endcase
   end

   // Highest active address bit and highest live threshold bit
   assign topBit = 5'(`FAF_BASE_HI_BIT) + {2'h0, extraHi};
   assign thrTopBit = 4'(`FAF_BASE_THR_HI) + {1'h0, extraHi};
   assign wordWidth = 7'(1) << lowBit;
   assign step = (ADDR_W+1)'(1) << lowBit;

   // Active address bits: always 11:5, widened by width and cascade
   genvar gi;
   generate
      for (gi = 0; gi < ADDR_W; gi++)
      begin : gAddrMask
         assign addrMask[gi] = (gi >= int'(lowBit)) && (gi <= int'(topBit));
      end
      for (gi = 0; gi < THR_W; gi++)
      begin : gThrMask
         assign thrMask[gi] = (gi <= int'(thrTopBit));
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Address counters

   logic [ADDR_W-1:0] wrPtr_reg;
   logic [ADDR_W-1:0] wrPtr_next;
   logic [ADDR_W-1:0] rdPtr_reg;
   logic [ADDR_W-1:0] rdPtr_next;
   logic wrWrap_reg;
   logic wrWrap_next;
   logic rdWrap_reg;
   logic rdWrap_next;
   logic [ADDR_W:0] wrSum;
   logic [ADDR_W:0] rdSum;
   logic writeAccept;
   logic readAccept;

   // A write is refused while full, a read while empty
   assign writeReady = !fullFlag;
   assign readReady = !emptyFlag;
   assign writeAccept = writeRequest && writeReady;
   assign readAccept = readRequest && readReady;
   assign wrSum = {1'b0, wrPtr_reg} + step;
   assign rdSum = {1'b0, rdPtr_reg} + step;

   // Step by one word; carry out of the top active bit flips the lap bit
   always_comb
   begin
      wrPtr_next = wrPtr_reg;
      wrWrap_next = wrWrap_reg;
      rdPtr_next = rdPtr_reg;
      rdWrap_next = rdWrap_reg;
      if (writeAccept)
      begin
         wrPtr_next = wrSum[ADDR_W-1:0] & addrMask;
         wrWrap_next = wrWrap_reg ^ wrSum[topBit + 5'h1];
      end
      if (readAccept)
      begin
         rdPtr_next = rdSum[ADDR_W-1:0] & addrMask;
         rdWrap_next = rdWrap_reg ^ rdSum[topBit + 5'h1];
      end
   end

   // Counter registers
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         wrPtr_reg <= `FAF_RST_PTR;
         rdPtr_reg <= `FAF_RST_PTR;
         wrWrap_reg <= 1'b0;
         rdWrap_reg <= 1'b0;
      end
      else
      begin
         wrPtr_reg <= wrPtr_next;
         rdPtr_reg <= rdPtr_next;
         wrWrap_reg <= wrWrap_next;
         rdWrap_reg <= rdWrap_next;
      end
   end

   assign writeAddress = wrPtr_reg;
   assign readAddress = rdPtr_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Storage: bit-addressed, 4k bits per block

   logic mem [0:MEM_BITS-1];
   logic [DATA_W-1:0] readData_reg;
   logic [DATA_W-1:0] readData_next;
   logic readDataValid_reg;
   logic memWrite;

   // Storage is left alone during reset even if a write request stands
   assign memWrite = writeAccept && !rst;

   // A word sits at its address and the bits above it, low bits are zero
   always_ff @(posedge core_clk)
   begin
      if (memWrite)
      begin
         for (int i = 0; i < DATA_W; i++)
         begin
            if (i < int'(wordWidth))
            begin
               mem[ADDR_W'(wrPtr_reg + ADDR_W'(i))] <= writeData[i];
            end
         end
      end
   end

   // Read word is gathered the same way, upper unused bits zero
   always_comb
   begin
      readData_next = readData_reg;
      if (readAccept)
      begin
         for (int i = 0; i < DATA_W; i++)
         begin
            if (i < int'(wordWidth))
            begin
               readData_next[i] = mem[ADDR_W'(rdPtr_reg + ADDR_W'(i))];
            end
            else
            begin
               readData_next[i] = 1'b0;
            end
         end
      end
   end

   // Read data register and one-cycle valid
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         readData_reg <= '0;
         readDataValid_reg <= 1'b0;
      end
      else
      begin
         readData_reg <= readData_next;
         readDataValid_reg <= readAccept;
      end
   end

   assign readData = readData_reg;
   assign readDataValid = readDataValid_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Fill level and flags

   logic [ADDR_W-1:0] fill_level_difference_reg;
   logic [ADDR_W-1:0] fill_level_difference_next;
   logic full_reg;
   logic full_next;
   logic empty_reg;
   logic empty_next;
   logic almostFull_reg;
   logic almostFull_next;
   logic almostEmpty_reg;
   logic almostEmpty_next;
   logic [THR_W-1:0] diffHi;
   logic [THR_W-1:0] afThr;
   logic [THR_W-1:0] aeThr;

   // Level from the next pointers, so it tracks each accepted transfer
   always_comb
   begin
      fill_level_difference_next = (wrPtr_next - rdPtr_next) & addrMask;
      full_next = (wrPtr_next == rdPtr_next) && (wrWrap_next != rdWrap_next);
      empty_next = (wrPtr_next == rdPtr_next) && (wrWrap_next == rdWrap_next);
   end

   // Only the live bits of each threshold take part
   assign diffHi = fill_level_difference_next[ADDR_W-1:`FAF_FILL_LEVEL_DIFFERENCE_CMP_LO];
   assign afThr = fullThresholdValue & thrMask;
   assign aeThr = emptyThresholdValue & thrMask;

   // Compare; a full FIFO wraps the level to zero, so full overrides
   always_comb
   begin
      almostFull_next = full_next || (diffHi >= afThr);
      almostEmpty_next = !full_next && (diffHi <= aeThr);
   end

   // Flag and level registers
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         fill_level_difference_reg <= `FAF_RST_PTR;
         full_reg <= 1'b0;
         empty_reg <= `FAF_RST_EMPTY;
         almostFull_reg <= 1'b0;
         almostEmpty_reg <= `FAF_RST_ALMOST_EMPTY_FLAG;
      end
      else
      begin
         fill_level_difference_reg <= fill_level_difference_next;
         full_reg <= full_next;
         empty_reg <= empty_next;
         almostFull_reg <= almostFull_next;
         almostEmpty_reg <= almostEmpty_next;
      end
   end

   assign fillLevelDifference = fill_level_difference_reg;
   assign fullFlag = full_reg;
   assign emptyFlag = empty_reg;
   assign almostFullFlag = almostFull_reg;
   assign almostEmptyFlag = almostEmpty_reg;

endmodule : faf_fifo_address_flag_logic

// [faf_flag_asserts.sv]
////////////////////////////////////////
module faf_flag_asserts
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [2:0] cascadeMode,
   input wire logic [2:0] widthMode,
   input wire logic [7:0] fullThresholdValue,
   input wire logic [7:0] emptyThresholdValue,
   input wire logic writeRequest,
   input wire logic writeReady,
   input wire logic readRequest,
   input wire logic readReady,
   input wire logic readDataValid,
   input wire logic [15:0] writeAddress,
   input wire logic [15:0] readAddress,
   input wire logic [15:0] fillLevelDifference,
   input wire logic fullFlag,
   input wire logic emptyFlag,
   input wire logic almostFullFlag,
   input wire logic almostEmptyFlag
);
   logic [2:0] casc;
   logic [15:0] step;
   logic [15:0] capMask;
   logic [7:0] thrMask;
   // Decoded configuration: word step, address mask, threshold mask
   always_comb
   begin
      casc = (cascadeMode > 3'h4) ? 3'h0 : cascadeMode;
      step = 16'h1 << ((widthMode > 3'h5) ? 3'h5 : widthMode);
      capMask = (16'h1000 << casc) - 16'h1;
      thrMask = 8'hFF >> (3'h4 - casc);
   end
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   sequence s_wr_taken;
      writeRequest && writeReady;
   endsequence
   sequence s_rd_taken;
      readRequest && readReady;
   endsequence
   a_low_bits_zero: assert property (
      ((writeAddress | readAddress) & (step - 16'h1)) == 16'h0)
      else $error("address bits below word step set");
   a_high_bits_zero: assert property (
      ((writeAddress | readAddress) & ~capMask) == 16'h0)
      else $error("address bits above capacity set");
   a_fill_level_difference_is_level: assert property (
      fillLevelDifference == ((writeAddress - readAddress) & capMask))
      else $error("difference not write minus read");
   a_empty_level: assert property (
      emptyFlag == ((writeAddress == readAddress) && !fullFlag))
      else $error("empty flag disagrees with pointers");
   a_write_step: assert property (
      s_wr_taken |=> writeAddress == (($past(writeAddress) + step) & capMask))
      else $error("write address step wrong");
   a_read_step: assert property (
      s_rd_taken |=> readDataValid && readAddress == (($past(readAddress) + step) & capMask))
      else $error("read address step or valid wrong");
   a_no_stray_valid: assert property (
      !(readRequest && readReady) |=> !readDataValid)
      else $error("valid without accepted read");
   a_full_holds: assert property (
      fullFlag && !readRequest |=> fullFlag && $stable(writeAddress))
      else $error("write taken while full");
   a_full_compare: assert property (
      !$past(rst) |-> almostFullFlag ==
         (fullFlag || fillLevelDifference[15:8] >= ($past(fullThresholdValue) & thrMask)))
      else $error("almost full compare wrong");
   a_empty_compare: assert property (
      !$past(rst) |-> almostEmptyFlag ==
         (!fullFlag && fillLevelDifference[15:8] <= ($past(emptyThresholdValue) & thrMask)))
      else $error("almost empty compare wrong");
endmodule : faf_flag_asserts
////////////////////////////////////////
bind faf_fifo_address_flag_logic faf_flag_asserts faf_flag_asserts_inst (.*);

// [faf_user_port.sv]
module faf_user_port
(
   input wire logic core_clk,
   output logic writeRequest,
   output logic [31:0] writeData,
   output logic readRequest
);
   timeunit 1ns;
   timeprecision 1ps;
   // Idle request lines from time zero
   initial
   begin
      writeRequest = 1'b0;
      writeData = 32'h0;
      readRequest = 1'b0;
   end
   // Back-to-back writes of base plus i; released data shows its inverse
   task automatic pushBurst(input int n, input logic [31:0] base);
      for (int i = 0; i < n; i++)
      begin
         @(posedge core_clk);
         #1;
         writeRequest = 1'b1;
         writeData = base + i;
      end
      @(posedge core_clk);
      #1;
      writeRequest = 1'b0;
      writeData = ~writeData;
   endtask : pushBurst
   // Back-to-back reads
   task automatic popBurst(input int n);
      repeat (n)
      begin
         @(posedge core_clk);
         #1;
         readRequest = 1'b1;
      end
      @(posedge core_clk);
      #1;
      readRequest = 1'b0;
   endtask : popBurst
endmodule : faf_user_port

// [test_faf_fifo_address_flag_logic.sv]
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin fails++; \
   $display("unexpected %s: expected %h seen %h", nm, ex, got); end end
module test_faf_fifo_address_flag_logic;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk, rst, writeRequest, writeReady, readRequest, readReady, readDataValid;
   logic [2:0] cascadeMode, widthMode;
   logic [7:0] fullThresholdValue, emptyThresholdValue;
   logic [31:0] writeData, readData;
   logic [15:0] writeAddress, readAddress, fillLevelDifference;
   logic fullFlag, emptyFlag, almostFullFlag, almostEmptyFlag;
   int checks, fails, c, w, words;
   faf_fifo_address_flag_logic faf_fifo_address_flag_logic_inst (.*);
   faf_user_port faf_user_port_inst (.*);
   // Clock
   initial
   begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   // Reset for ten cycles with a new configuration
   task doReset(input logic [2:0] cm, input logic [2:0] wm);
      @(posedge core_clk);
      #1;
      rst = 1'b1;
      cascadeMode = cm;
      widthMode = wm;
      repeat (10) @(posedge core_clk);
      #1;
      rst = 1'b0;
   endtask : doReset
   // Verdict and end of run
   task stop_test();
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : stop_test
   // Hang guard
   initial
   begin
      // The tests take about 4200 cycles; this allows more than four times that
      #200000;
      fails++;
      stop_test();
   end
   ////////////////////////////////////////
   // Main sequence
   initial
   begin
      rst = 1'b1;
      cascadeMode = 3'h0;
      widthMode = 3'h5;
      fullThresholdValue = 8'hFF;
      emptyThresholdValue = 8'hF0;
      doReset(3'h0, 3'h5);
      `CHK("almostEmptyFlag", 1'b1, almostEmptyFlag)
      `CHK("almostFullFlag", 1'b0, almostFullFlag)
      `CHK("emptyFlag", 1'b1, emptyFlag)
      `CHK("readReady", 1'b0, readReady)
      `CHK("writeReady", 1'b1, writeReady)
      `CHK("readData", 32'h0, readData)
      // Word width sweep with four blocks; a read on empty is refused first
      for (w = 0; w < 6; w++)
      begin
         doReset(3'h2, w[2:0]);
         faf_user_port_inst.popBurst(1);
         `CHK("readDataValid", 1'b0, readDataValid)
         `CHK("readAddress", 16'h0, readAddress)
         faf_user_port_inst.pushBurst(2, 32'hFFFFFFFF);
         `CHK("writeAddress", 16'h2 << w, writeAddress)
         `CHK("emptyFlag", 1'b0, emptyFlag)
         faf_user_port_inst.popBurst(1);
         `CHK("readData", 32'hFFFFFFFF >> (32 - (1 << w)), readData)
         `CHK("readDataValid", 1'b1, readDataValid)
         `CHK("readAddress", 16'h1 << w, readAddress)
         `CHK("fillLevelDifference", 16'h1 << w, fillLevelDifference)
      end
      // Cascade sweep at 32-bit words: threshold masks and capacity
      for (c = 0; c < 5; c++)
      begin
         doReset(c[2:0], 3'h5);
         `CHK("emptyFlag", 1'b1, emptyFlag)
         `CHK("fillLevelDifference", 16'h0, fillLevelDifference)
         words = ((16 << c) - 1) * 8;
         faf_user_port_inst.pushBurst(8, 32'hC0DE0000);
         `CHK("almostEmptyFlag", c != 0, almostEmptyFlag)
         faf_user_port_inst.pushBurst(words - 9, 32'hC0DE0008);
         `CHK("almostFullFlag", 1'b0, almostFullFlag)
         faf_user_port_inst.pushBurst(1, 32'h0);
         `CHK("almostFullFlag", 1'b1, almostFullFlag)
         `CHK("writeAddress", 16'(words * 32), writeAddress)
         faf_user_port_inst.pushBurst((128 << c) - words, 32'h0);
         `CHK("fullFlag", 1'b1, fullFlag)
         `CHK("writeReady", 1'b0, writeReady)
         `CHK("writeAddress", 16'h0, writeAddress)
         faf_user_port_inst.pushBurst(1, 32'h5A5A5A5A);
         `CHK("fillLevelDifference", 16'h0, fillLevelDifference)
         faf_user_port_inst.popBurst(1);
         `CHK("readData", 32'hC0DE0000, readData)
         `CHK("fullFlag", 1'b0, fullFlag)
         `CHK("almostFullFlag", 1'b1, almostFullFlag)
         `CHK("fillLevelDifference", 16'((4096 << c) - 32), fillLevelDifference)
      end
      stop_test();
   end
endmodule : test_faf_fifo_address_flag_logic
